// ===== logic/supervisor_pkg.sv
// constants and carrier types for the supervisor sequencer
package supervisor_pkg;
	localparam int unsigned CLOCK_HZ          = 25000000;
	localparam int unsigned CLOCK_NS          = 40;
	// reset request filter: reject below 50 ns, guarantee at 200 ns; threshold chosen at 120 ns
	localparam int unsigned REJECT_NS         = 50;
	localparam int unsigned GUARANTEE_NS      = 200;
	localparam int unsigned FILTER_NS         = 120;
	localparam int unsigned FILTER_CYCLES     = (FILTER_NS + CLOCK_NS - 1) / CLOCK_NS;
	// reset stretch and recovery interval, chosen inside 40..200 ms
	localparam int unsigned STRETCH_MIN_MS    = 40;
	localparam int unsigned STRETCH_MAX_MS    = 200;
	localparam int unsigned STRETCH_MS        = 100;
	localparam int unsigned STRETCH_CYCLES    = STRETCH_MS * (CLOCK_HZ / 1000);
	localparam int unsigned CHECK_HOURS       = 24;
	localparam longint unsigned CHECK_CYCLES  = longint'(CHECK_HOURS) * 3600 * CLOCK_HZ;
	localparam int          FILTER_W          = 3;
	localparam int          STRETCH_W         = 24;
	localparam int          CHECK_W           = 42;
	// synchroniser width and idle level: every pin reads high right after reset
	localparam int          SYNC_W            = 4;
	localparam logic [SYNC_W-1:0] SYNC_IDLE   = 4'hf;

	typedef enum logic [1:0] {
		PWR_OFF     = 2'b00,
		PWR_RECOVER = 2'b01,
		PWR_RUN     = 2'b10
	} power_state_type;

	// analog comparator results sampled by the sequencer
	typedef struct packed {
		logic supply_ok;
		logic battery_ok;
		logic sense_above;
	} sense_type;
endpackage

// ===== logic/supervisor_sequencer.sv
// reset stretcher, battery monitor and power-fail gating sequencer
// How it works
// - a reset request held low 200 ns or longer always produces a reset
// - reset output stays low 40 to 200 ms after the request returns high
// - request pulses shorter than 50 ns are filtered out and cause nothing
// - request reset uses the same stretch as the power-up reset
// - battery checked once at power-up and then every 24 hours
// - a failing battery check asserts the active-low battery-low output
// - battery-low stays asserted until a later check passes
// - no battery check while running from backup, only with nominal supply
// - in run state power-fail flag goes low when sense input is below threshold
// - in backup the comparator is off and power-fail flag is held low
// - on power return the flag is forced high for the recovery interval, then tracks
`timescale 1ns/1ps
module supervisor_sequencer
	import supervisor_pkg::*;
#(
	parameter int unsigned STRETCH_LEN = STRETCH_CYCLES,
	parameter longint unsigned CHECK_LEN = CHECK_CYCLES
) (
	input  wire logic i_clock,
	input  wire logic i_rstn,
	input  wire logic i_reset_request_in,
	input  wire logic i_supply_ok,
	input  wire logic i_battery_ok,
	input  wire logic i_power_fail_sense_in,
	output logic      o_reset_oe_n,
	output logic      o_battery_low_oe_n,
	output logic      o_battery_low_n,
	output logic      o_power_fail_flag_n
);
	sense_type        sensed;
	logic             request_sync;
	power_state_type  state_r;
	logic [FILTER_W-1:0]  filter_cnt_r;
	logic             request_hit_r;
	logic [STRETCH_W-1:0] stretch_cnt_r;
	logic [CHECK_W-1:0]   check_cnt_r;
	logic             check_due_r;
	logic             battery_low_r;
	logic [SYNC_W-1:0]    async_in;
	logic [SYNC_W-1:0]    sync_out;
	logic             filter_full;
	logic             stretch_load;
	logic             stretch_done;
	logic             reset_release;
	logic             in_off;
	logic             in_run;
	logic             check_wrap;
	logic             check_now;

	// pin and comparator levels travel through the synchroniser as one vector
	assign async_in = {i_supply_ok, i_battery_ok, i_power_fail_sense_in, i_reset_request_in};
	assign {sensed.supply_ok, sensed.battery_ok, sensed.sense_above, request_sync} = sync_out;

	// state decodes shared by the timer and battery processes
	assign in_off = (state_r == PWR_OFF);
	assign in_run = (state_r == PWR_RUN);

	// counter end points, named once so that every process agrees on them
	assign filter_full   = (filter_cnt_r == FILTER_W'(FILTER_CYCLES - 1));
	assign stretch_done  = (stretch_cnt_r == '0);
	assign check_wrap    = (check_cnt_r == CHECK_W'(CHECK_LEN - 1));
	// supply loss and a live request both restart the stretch from full length
	assign stretch_load  = !sensed.supply_ok || request_hit_r;
	// release needs a finished stretch, good supply and no request still held
	assign reset_release = stretch_done && sensed.supply_ok && !request_hit_r;
	// a check samples the battery only in run, never from backup
	assign check_now     = check_due_r && in_run && sensed.supply_ok;

	// asynchronous analog and pin levels are synchronised before use
	sync_filter #(
		.WIDTH (SYNC_W)
	) u_sync (
		.i_clock     (i_clock),
		.i_rstn      (i_rstn),
		.i_async     (async_in),
		.i_reset_val (SYNC_IDLE),
		.o_sync      (sync_out)
	);

	// low-width filter: a request counts once it has stayed low FILTER_CYCLES
	// any high sample restarts the count, so two short pulses never add up
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			filter_cnt_r  <= '0;
			request_hit_r <= 1'b0;
		end else if (request_sync) begin
			filter_cnt_r  <= '0;
			request_hit_r <= 1'b0;
		end else if (filter_full) begin
			request_hit_r <= 1'b1;
		end else begin
			filter_cnt_r <= filter_cnt_r + FILTER_W'(1);
		end
	end

	// power state: supply loss means backup, return runs the recovery interval
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			state_r <= PWR_OFF;
		end else begin
			case (state_r)
				PWR_OFF: begin
					if (sensed.supply_ok) begin
						state_r <= PWR_RECOVER;
					end
				end
				PWR_RECOVER: begin
					if (!sensed.supply_ok) begin
						state_r <= PWR_OFF;
					end else if (stretch_done) begin
						state_r <= PWR_RUN;
					end
				end
				PWR_RUN: begin
					if (!sensed.supply_ok) begin
						state_r <= PWR_OFF;
					end
				end
				default: begin
					state_r <= PWR_OFF;
				end
			endcase
		end
	end

	// one stretch counter serves power-up and request resets alike
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			stretch_cnt_r <= STRETCH_W'(STRETCH_LEN);
		end else if (stretch_load) begin
			stretch_cnt_r <= STRETCH_W'(STRETCH_LEN);
		end else if (!stretch_done) begin
			stretch_cnt_r <= stretch_cnt_r - STRETCH_W'(1);
		end
	end

	// reset drives low until the stretch expires after supply and request are good
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			o_reset_oe_n <= 1'b0;
		end else begin
			// high lets the line float to its pull-up, low holds the host in reset
			o_reset_oe_n <= reset_release;
		end
	end

	// periodic check timer only runs on nominal supply; a power-up arms a check
	// the schedule restarts at every power-up, so time on backup never counts
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			check_cnt_r <= '0;
			check_due_r <= 1'b1;
		end else if (in_off) begin
			check_cnt_r <= '0;
			check_due_r <= 1'b1;
		end else if (in_run) begin
			if (check_due_r) begin
				check_due_r <= 1'b0;
			end else if (check_wrap) begin
				check_cnt_r <= '0;
				check_due_r <= 1'b1;
			end else begin
				check_cnt_r <= check_cnt_r + CHECK_W'(1);
			end
		end
	end

	// battery flag is sticky between checks; never sampled from backup
	// a fresh battery shows only after the next check, not at the swap itself
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			battery_low_r <= 1'b0;
		end else if (check_now) begin
			battery_low_r <= !sensed.battery_ok;
		end
	end

	// pull-down enable: low drags the open-drain line down
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			o_battery_low_oe_n <= 1'b1;
		end else begin
			o_battery_low_oe_n <= !battery_low_r;
		end
	end

	// level copy from the same flag, so the two can never disagree
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			o_battery_low_n <= 1'b1;
		end else begin
			o_battery_low_n <= !battery_low_r;
		end
	end

	// power-fail flag: low in backup, high while recovering, then follows the sense
	// push-pull level, so low during reset is the safe reading for the host
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			o_power_fail_flag_n <= 1'b0;
		end else begin
			case (state_r)
				PWR_OFF: begin
					o_power_fail_flag_n <= 1'b0;
				end
				PWR_RECOVER: begin
					o_power_fail_flag_n <= 1'b1;
				end
				PWR_RUN: begin
					o_power_fail_flag_n <= sensed.sense_above;
				end
				default: begin
					o_power_fail_flag_n <= 1'b0;
				end
			endcase
		end
	end
endmodule

// ===== logic/sync_filter.sv
// two-flop synchroniser for the analog comparator and pin inputs
`timescale 1ns/1ps
module sync_filter
	import supervisor_pkg::*;
#(
	parameter int WIDTH = 4
) (
	input  wire logic             i_clock,
	input  wire logic             i_rstn,
	input  wire logic [WIDTH-1:0] i_async,
	input  wire logic [WIDTH-1:0] i_reset_val,
	output logic      [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] stage1_r;
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			always_ff @(posedge i_clock) begin
				if (!i_rstn) begin
					stage1_r[g] <= i_reset_val[g];
					o_sync[g]   <= i_reset_val[g];
				end else begin
					stage1_r[g] <= i_async[g];
					o_sync[g]   <= stage1_r[g];
				end
			end
		end
	endgenerate
endmodule

// ===== tb/host_model.sv
// host side of the open-drain lines
`timescale 1ns/1ps
module host_model (
	input  wire logic i_reset_oe_n,
	input  wire logic i_battery_low_oe_n,
	output logic      o_reset_line,
	output logic      o_battery_low_line
);
	assign o_reset_line       = i_reset_oe_n; // pull-up when released
	assign o_battery_low_line = i_battery_low_oe_n; // pull-up when released
endmodule

// ===== tb/supervisor_sequencer_test.sv
// self-checking bench for the supervisor sequencer
`timescale 1ns/1ps
module supervisor_sequencer_test;
	localparam int SL = 20;
	logic clk = 1'b0, rstn, rq_n, sup, bat, sn;
	logic ro_n, bo_n, bl_n, pf_n, rl, bll;
	wire  [3:0] o = {bl_n, pf_n, bll, rl};
	int   n_fail = 0;
	int   tests_run = 0;
	initial forever #20 clk = ~clk;
	host_model u_host (.i_reset_oe_n(ro_n), .i_battery_low_oe_n(bo_n), .o_reset_line(rl), .o_battery_low_line(bll));
	supervisor_sequencer #(.STRETCH_LEN(SL), .CHECK_LEN(50)) u_dut (.i_clock(clk), .i_rstn(rstn),
		.i_reset_request_in(rq_n), .i_supply_ok(sup), .i_battery_ok(bat), .i_power_fail_sense_in(sn),
		.o_reset_oe_n(ro_n), .o_battery_low_oe_n(bo_n), .o_battery_low_n(bl_n), .o_power_fail_flag_n(pf_n));
	task automatic wt(int k, logic v, int n);
		for (int i = 0; i < n && o[k] !== v; i++)
			@(negedge clk);
		tests_run++;
		n_fail += int'(o[k] !== v);
		if (o[k] !== v)
			$display("[ERR] %s exp %b got %b", (k == 0) ? "reset_line" : (k == 1) ? "battery_low_line"
				: (k == 2) ? "power_fail_flag_n" : "battery_low_n", v, o[k]);
	endtask
	task t_glitch;
		rq_n = 1'b0;
		repeat (2) @(negedge clk);
		rq_n = 1'b1;
		repeat (10) @(negedge clk) wt(0, 1'b1, 0);
	endtask
	task t_request;
		rq_n = 1'b0;
		repeat (5) @(negedge clk);
		rq_n = 1'b1;
		wt(0, 1'b0, 4);
		repeat (SL) @(negedge clk) wt(0, 1'b0, 0);
		wt(0, 1'b1, 8);
	endtask
	task t_power;
		sup = 1'b0;
		wt(2, 1'b0, 5);
		bat = 1'b0;
		repeat (10) @(negedge clk) wt(1, 1'b1, 0);
		{sn, sup} = 2'h1;
		wt(2, 1'b1, 6);
		repeat (SL - 6) @(negedge clk) wt(2, 1'b1, 0);
		wt(0, 1'b1, 14);
		wt(1, 1'b0, 4);
		wt(3, 1'b0, 2);
		wt(2, 1'b0, 6);
		bat = 1'b1;
		repeat (20) @(negedge clk) wt(1, 1'b0, 0);
		wt(1, 1'b1, 40);
		wt(3, 1'b1, 2);
	endtask
	task wrap_up;
		if (n_fail == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		#120us;
		n_fail++;
		wrap_up;
	end
	initial begin
		{rstn, rq_n, sup, bat, sn} = 5'h0f;
		repeat (16) @(negedge clk);
		rstn = 1'b1;
		wt(0, 1'b1, SL + 10);
		t_glitch;
		t_request;
		t_power;
		wrap_up;
	end
endmodule

// ===== tb/supervisor_sva.sv
// pin checks for the sequencer
`timescale 1ns/1ps
module supervisor_sva (
	input wire logic i_clock,
	input wire logic i_rstn,
	input wire logic i_reset_request_in,
	input wire logic i_supply_ok,
	input wire logic i_battery_ok,
	input wire logic i_power_fail_sense_in,
	input wire logic o_reset_oe_n,
	input wire logic o_battery_low_oe_n,
	input wire logic o_battery_low_n,
	input wire logic o_power_fail_flag_n
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rstn);
	sequence s_up; !i_supply_ok[*4] ##1 i_supply_ok[*6]; endsequence
	a_bl_copy: assert property (o_battery_low_n == o_battery_low_oe_n) else $error("bl copy");
	a_req_reset: assert property (!i_reset_request_in[*5] |-> ##[0:3] !o_reset_oe_n) else $error("no reset");
	a_glitch_skip: assert property ($rose(i_reset_request_in) && $past(i_reset_request_in, 3)
		&& o_reset_oe_n |-> (o_reset_oe_n || !i_supply_ok)[*4]) else $error("glitch");
	a_stretch_min: assert property ($fell(o_reset_oe_n) |-> !o_reset_oe_n[*8]) else $error("short");
	a_loss_reset: assert property ($fell(i_supply_ok) |-> ##[1:5] !(o_power_fail_flag_n || o_reset_oe_n))
		else $error("loss");
	a_backup_hold: assert property (!i_supply_ok[*8] |-> !o_power_fail_flag_n && $stable(o_battery_low_n))
		else $error("backup");
	a_recover_high: assert property (s_up |-> o_power_fail_flag_n) else $error("recover");
	a_pf_track: assert property ((!i_power_fail_sense_in && o_reset_oe_n && i_supply_ok)[*4]
		|-> !o_power_fail_flag_n) else $error("track");
endmodule
bind supervisor_sequencer supervisor_sva u_sva (.*);
